// >>> include/scss_pkg.sv
package scss_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] OFS_REQ = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_IRQ_STS = 12'h008;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h00C;
    localparam logic [11:0] OFS_INFO = 12'h010;
    // Field positions inside the request and status registers.
    localparam int SRC_LSB = 4;
    localparam int DIV_LSB = 0;
    localparam int UNIMP_BIT = 7;
    // Source and PLL combination codes.
    localparam logic [2:0] SRC_EXT = 3'h7;
    localparam logic [2:0] SRC_FAST = 3'h6;
    localparam logic [2:0] SRC_SLOW = 3'h5;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_RSV_HI = 3'h3;
    localparam logic [2:0] SRC_EXT_PLL = 3'h2;
    localparam logic [2:0] SRC_RSV_LO = 3'h1;
    localparam logic [2:0] FUSE_FAST_64 = 3'h0;
    // Postscaler codes, powers of two.
    localparam logic [3:0] DIV_1 = 4'h0;
    localparam logic [3:0] DIV_4 = 4'h2;
    localparam logic [3:0] DIV_MAX = 4'h9;
    // Internal frequency selections used at reset.
    localparam logic [3:0] FREQ_4MHZ = 4'h2;
    localparam logic [3:0] FREQ_64MHZ = 4'h8;
    // Reset values of the state held before the fuses are loaded.
    localparam logic [2:0] RST_SRC = 3'h6;
    localparam logic [3:0] RST_DIV = 4'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // External mode fuse codes.
    localparam logic [2:0] EXT_CLK_LOW = 3'h0;
    localparam logic [2:0] EXT_CLK_MED = 3'h1;
    localparam logic [2:0] EXT_CLK_HIGH = 3'h2;
    localparam logic [2:0] EXT_LP_XTAL = 3'h3;
    localparam logic [2:0] EXT_MED_RES = 3'h4;
    localparam logic [2:0] EXT_HIGH_RES = 3'h5;
    // Interrupt event bit positions.
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_REJECT = 2;
    localparam int EV_NUM = 3;
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int FAIL_TIMEOUT_NS = 2000;
    localparam int FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam int OST_TICKS = 1024;
    // Clock switch sequencer states, Gray coded.
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SWITCH = 2'b11
    } scss_state_e;
endpackage

// >>> rtl/scss_ext_monitor.sv
// Startup timer and loss detector for the external oscillator.
module scss_ext_monitor
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic ext_tick_i,
    input wire logic watch_i,
    input wire logic crystal_i,
    output logic stable_o,
    output logic fail_o
);
    logic [10:0] ost_cnt_r;
    logic [7:0] idle_cnt_r;
    logic ost_done;
    logic timed_out;

    assign ost_done = (ost_cnt_r == 11'(scss_pkg::OST_TICKS));
    assign timed_out = (idle_cnt_r == 8'(scss_pkg::FAIL_TIMEOUT_CYC));
    // Clock inputs need no startup count, only crystals and resonators do.
    assign stable_o = watch_i && (!crystal_i || ost_done);
    assign fail_o = watch_i && timed_out;

    // Counts oscillator ticks; restarts whenever the oscillator is dropped or lost.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ost_cnt_r <= 11'h000;
        else if (clk_en_i)
        begin
            if (!watch_i || timed_out)
                ost_cnt_r <= 11'h000;
            else if (ext_tick_i && !ost_done)
                ost_cnt_r <= ost_cnt_r + 11'h001;
        end
    end

    // Counts system cycles since the last tick and saturates at the timeout.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            idle_cnt_r <= 8'h00;
        else if (clk_en_i)
        begin
            if (!watch_i || ext_tick_i)
                idle_cnt_r <= 8'h00;
            else if (!timed_out)
                idle_cnt_r <= idle_cnt_r + 8'h01;
        end
    end
endmodule

// >>> rtl/scss_top.sv
// Chosen here: the APB slave port and the register offsets.
module scss_top
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [2:0] reset_source_fuse_i,
    input wire logic [2:0] external_mode_fuse_i,
    input wire logic switch_permit_fuse_i,
    input wire logic ext_tick_i,
    input wire logic ext_ready_i,
    input wire logic fast_ready_i,
    input wire logic slow_ready_i,
    input wire logic sec_ready_i,
    input wire logic pll_lock_i,
    output logic [2:0] clk_src_sel_o,
    output logic [3:0] clk_div_o,
    output logic [3:0] int_freq_sel_o,
    output logic [2:0] ext_mode_o,
    output logic switch_done_o,
    output logic irq_o
);
    localparam int EV_BITS = scss_pkg::EV_NUM;
    localparam int UNIMP = scss_pkg::UNIMP_BIT;
    localparam int EV_FAIL_B = scss_pkg::EV_FAIL;

    logic loaded_r;
    logic [2:0] fuse_src_r;
    logic [2:0] ext_mode_r;
    logic permit_r;
    logic [2:0] req_src_r;
    logic [3:0] req_div_r;
    logic [2:0] cur_src_r;
    logic [3:0] cur_div_r;
    logic [3:0] freq_r;
    logic [EV_BITS-1:0] irq_sts_r;
    logic [EV_BITS-1:0] irq_msk_r;
    logic [EV_BITS-1:0] events;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    scss_pkg::scss_state_e state_r;
    scss_pkg::scss_state_e state_nxt;
    logic access;
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic wr_req;
    logic rsv_wr;
    logic tgt_ready;
    logic crystal;
    logic ext_stable;
    logic ext_fail;
    logic cur_is_ext;
    logic req_is_ext;
    logic fail_d_r;
    logic fallback;
    logic done;

    // Default source for a given fuse; reserved fuse codes fall back to fast internal.
    function automatic logic [2:0] fuse_src(input logic [2:0] f);
        if (f == scss_pkg::FUSE_FAST_64 || f == scss_pkg::SRC_RSV_HI
            || f == scss_pkg::SRC_RSV_LO)
            return scss_pkg::SRC_FAST;
        return f;
    endfunction

    // Default divider for a given fuse.
    function automatic logic [3:0] fuse_div(input logic [2:0] f);
        return (f == scss_pkg::SRC_FAST) ? scss_pkg::DIV_4 : scss_pkg::DIV_1;
    endfunction

    // APB decode; the slave never waits once the fuses are loaded.
    assign access = psel_i && penable_i && pready_o;
    assign wr_access = access && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign mapped = paddr_i == scss_pkg::OFS_REQ || paddr_i == scss_pkg::OFS_STAT
        || paddr_i == scss_pkg::OFS_IRQ_STS || paddr_i == scss_pkg::OFS_IRQ_MSK
        || paddr_i == scss_pkg::OFS_INFO;
    assign pready_o = loaded_r;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_r;
    assign wr_req = clk_en_i && wr_access && paddr_i == scss_pkg::OFS_REQ;
    // A reserved divider is dropped as well, so the postscaler never sees one.
    assign rsv_wr = pwdata_i[6:4] == scss_pkg::SRC_RSV_HI
        || pwdata_i[6:4] == scss_pkg::SRC_RSV_LO
        || pwdata_i[3:0] > scss_pkg::DIV_MAX;

    // Crystal and resonator modes need the startup count; clock inputs do not.
    assign crystal = ext_mode_r == scss_pkg::EXT_LP_XTAL
        || ext_mode_r == scss_pkg::EXT_MED_RES
        || ext_mode_r == scss_pkg::EXT_HIGH_RES;
    assign cur_is_ext = cur_src_r == scss_pkg::SRC_EXT || cur_src_r == scss_pkg::SRC_EXT_PLL;
    assign req_is_ext = req_src_r == scss_pkg::SRC_EXT || req_src_r == scss_pkg::SRC_EXT_PLL;

    scss_ext_monitor u_mon
    (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .ext_tick_i(ext_tick_i),
        .watch_i(loaded_r && (cur_is_ext || req_is_ext)),
        .crystal_i(crystal),
        .stable_o(ext_stable),
        .fail_o(ext_fail)
    );

    // Readiness of the requested source and PLL combination.
    always_comb
    begin
        case (req_src_r)
            scss_pkg::SRC_EXT: tgt_ready = ext_ready_i && ext_stable;
            scss_pkg::SRC_EXT_PLL: tgt_ready = ext_ready_i && ext_stable && pll_lock_i;
            scss_pkg::SRC_FAST: tgt_ready = fast_ready_i;
            scss_pkg::SRC_SLOW: tgt_ready = slow_ready_i;
            scss_pkg::SRC_SEC: tgt_ready = sec_ready_i;
            default: tgt_ready = 1'b0;
        endcase
    end

    // Fallback fires once, on the cycle the loss appears while running external.
    assign fallback = ext_fail && !fail_d_r && cur_is_ext && loaded_r;
    assign done = cur_src_r == req_src_r && cur_div_r == req_div_r;
    assign switch_done_o = done;

    // Fuses are straps: caught on the first enabled edge after reset release.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            loaded_r <= 1'b0;
            fuse_src_r <= scss_pkg::RST_SRC;
            ext_mode_r <= scss_pkg::EXT_CLK_LOW;
            permit_r <= 1'b0;
            freq_r <= scss_pkg::FREQ_4MHZ;
            fail_d_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            fail_d_r <= ext_fail;
            if (!loaded_r)
            begin
                loaded_r <= 1'b1;
                fuse_src_r <= reset_source_fuse_i;
                ext_mode_r <= external_mode_fuse_i;
                permit_r <= switch_permit_fuse_i;
                freq_r <= (reset_source_fuse_i == scss_pkg::FUSE_FAST_64)
                    ? scss_pkg::FREQ_64MHZ : scss_pkg::FREQ_4MHZ;
            end
        end
    end

    // Request register: fuse defaults, then guarded software writes.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            req_src_r <= scss_pkg::RST_SRC;
            req_div_r <= scss_pkg::RST_DIV;
        end
        else if (clk_en_i)
        begin
            if (!loaded_r)
            begin
                req_src_r <= fuse_src(reset_source_fuse_i);
                req_div_r <= fuse_div(reset_source_fuse_i);
            end
            else if (fallback)
                req_src_r <= scss_pkg::SRC_FAST;
            else if (wr_req && permit_r && !rsv_wr)
            begin
                req_src_r <= pwdata_i[6:4];
                req_div_r <= pwdata_i[3:0];
            end
        end
    end

    // Sequencer: wait for the new source, then move in one clean step.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            scss_pkg::ST_IDLE:
                if (loaded_r && !done)
                    state_nxt = scss_pkg::ST_WAIT;
            scss_pkg::ST_WAIT:
                if (done)
                    state_nxt = scss_pkg::ST_IDLE;
                else if (tgt_ready)
                    state_nxt = scss_pkg::ST_SWITCH;
            scss_pkg::ST_SWITCH:
                state_nxt = scss_pkg::ST_IDLE;
            default:
                state_nxt = scss_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_r <= scss_pkg::ST_IDLE;
        else if (clk_en_i)
            state_r <= fallback ? scss_pkg::ST_IDLE : state_nxt;
    end

    // Current source and divider follow the request through the sequencer; a fallback forces the fast source directly.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cur_src_r <= scss_pkg::RST_SRC;
            cur_div_r <= scss_pkg::RST_DIV;
        end
        else if (clk_en_i)
        begin
            if (!loaded_r)
            begin
                cur_src_r <= fuse_src(reset_source_fuse_i);
                cur_div_r <= fuse_div(reset_source_fuse_i);
            end
            else if (fallback)
                cur_src_r <= scss_pkg::SRC_FAST;
            else if (state_r == scss_pkg::ST_SWITCH)
            begin
                cur_src_r <= req_src_r;
                cur_div_r <= req_div_r;
            end
        end
    end

    assign clk_src_sel_o = cur_src_r;
    assign clk_div_o = cur_div_r;
    assign int_freq_sel_o = freq_r;
    assign ext_mode_o = ext_mode_r;

    // Events: switch finished, clock lost, request write dropped.
    assign events[scss_pkg::EV_DONE] = state_r == scss_pkg::ST_SWITCH;
    assign events[scss_pkg::EV_FAIL] = fallback;
    assign events[scss_pkg::EV_REJECT] = wr_req && (!permit_r || rsv_wr);

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            irq_sts_r <= scss_pkg::RST_IRQ;
            irq_msk_r <= scss_pkg::RST_IRQ;
        end
        else if (clk_en_i)
        begin
            if (wr_access && paddr_i == scss_pkg::OFS_IRQ_MSK)
                irq_msk_r <= pwdata_i[EV_BITS-1:0];
            if (wr_access && paddr_i == scss_pkg::OFS_IRQ_STS)
                irq_sts_r <= (irq_sts_r & ~pwdata_i[EV_BITS-1:0]) | events;
            else
                irq_sts_r <= irq_sts_r | events;
        end
    end

    assign irq_o = |(irq_sts_r & irq_msk_r);

    // Read data is captured in the setup phase so it comes from a flip-flop.
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        case (paddr_i)
            scss_pkg::OFS_REQ: rd_nxt[6:0] = {req_src_r, req_div_r};
            scss_pkg::OFS_STAT: rd_nxt[6:0] = {cur_src_r, cur_div_r};
            scss_pkg::OFS_IRQ_STS: rd_nxt[EV_BITS-1:0] = irq_sts_r;
            scss_pkg::OFS_IRQ_MSK: rd_nxt[EV_BITS-1:0] = irq_msk_r;
            scss_pkg::OFS_INFO: rd_nxt[5:0] = {permit_r, ext_stable, tgt_ready,
                cur_is_ext, state_r != scss_pkg::ST_IDLE, done};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Bit 7 and above stay zero for every register.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            prdata_r <= 32'h0000_0000;
        else if (clk_en_i && rd_setup)
            prdata_r <= rd_nxt;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_RSV_DISCARD: assert property (
        wr_req && pwdata_i[6:4] == scss_pkg::SRC_RSV_HI && !fallback
        |=> $stable(req_src_r) && $stable(req_div_r))
        else $error("Reserved source write changed the request.");
    AST_LOCKED: assert property (
        wr_req && !permit_r && !fallback |=> $stable(req_src_r) && $stable(req_div_r))
        else $error("Request changed while switching is not permitted.");
    AST_WRITE_TAKES: assert property (
        wr_req && permit_r && !rsv_wr && !fallback
        |=> req_src_r == $past(pwdata_i[6:4]) && req_div_r == $past(pwdata_i[3:0]))
        else $error("Valid request write was not stored.");
    AST_RESET_LOAD: assert property (
        $rose(loaded_r) |-> cur_src_r == req_src_r && cur_div_r == req_div_r
        && req_src_r == fuse_src(fuse_src_r) && req_div_r == fuse_div(fuse_src_r))
        else $error("Reset defaults do not follow the source fuse.");
    AST_STATUS_READ: assert property (
        clk_en_i && rd_setup && paddr_i == scss_pkg::OFS_STAT
        |=> prdata_o[6:0] == $past({cur_src_r, cur_div_r}))
        else $error("Status read does not show current source and divider.");
    AST_BIT7_ZERO: assert property (
        psel_i && penable_i && !pwrite_i |-> prdata_o[UNIMP] == 1'b0)
        else $error("Unimplemented bit 7 read as one.");
    AST_HOLD: assert property (
        clk_en_i && state_r == scss_pkg::ST_WAIT && !tgt_ready && !fallback
        |=> $stable(cur_src_r) && $stable(cur_div_r))
        else $error("Source changed before the new source was ready.");
    AST_CRYSTAL: assert property (
        state_r == scss_pkg::ST_SWITCH && req_is_ext && crystal |-> ext_stable)
        else $error("Crystal used before its startup count finished.");
    AST_FAILSAFE: assert property (
        clk_en_i && fallback |=> cur_src_r == scss_pkg::SRC_FAST && irq_sts_r[EV_FAIL_B])
        else $error("External clock loss did not move to the fast internal source.");
    AST_DONE: assert property (
        clk_en_i && state_r == scss_pkg::ST_SWITCH && !fallback
        |=> cur_src_r == $past(req_src_r) && cur_div_r == $past(req_div_r))
        else $error("Switch did not complete to the requested setting.");

    COV_SWITCH: cover property (
        state_r == scss_pkg::ST_WAIT ##[1:50] state_r == scss_pkg::ST_SWITCH);
    COV_FAIL: cover property (fallback);
    COV_REJECT: cover property (events[scss_pkg::EV_REJECT]);
endmodule

// >>> dv/scss_top_tb.sv
module scss_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] rfuse = 3'h6;
    logic [2:0] mfuse = 3'h0;
    logic permit = 1'b1;
    logic tick = 1'b0;
    logic tick_on = 1'b1;
    logic ext_rdy = 1'b1;
    logic fast_rdy = 1'b1;
    logic slow_rdy = 1'b1;
    logic sec_rdy = 1'b1;
    logic pll_lock = 1'b1;
    logic [2:0] src;
    logic [3:0] div;
    logic [3:0] freq;
    logic [2:0] emode;
    logic done;
    logic irq;
    logic [31:0] rd;
    logic err;
    logic [2:0] es;
    logic [3:0] ed;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;

    scss_top dut_u (.sys_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .reset_source_fuse_i(rfuse), .external_mode_fuse_i(mfuse),
        .switch_permit_fuse_i(permit), .ext_tick_i(tick), .ext_ready_i(ext_rdy),
        .fast_ready_i(fast_rdy), .slow_ready_i(slow_rdy), .sec_ready_i(sec_rdy),
        .pll_lock_i(pll_lock), .clk_src_sel_o(src), .clk_div_o(div),
        .int_freq_sel_o(freq), .ext_mode_o(emode), .switch_done_o(done), .irq_o(irq));

    // The clock runs at 100 MHz.
    always #5 clk = ~clk;

    // The oscillator tick pulses every other cycle; stopping it models a lost external clock.
    always @(posedge clk)
    begin
        tick <= tick_on & ~tick;
    end

    // A hung handshake would stall forever, so a cycle ceiling ends the run.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Word comparison.
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: word %h wanted %h", $time, got, exp);
        end
    endtask

    // Single flag comparison.
    task automatic chk_b(input logic got, input logic exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: flag %b wanted %b", $time, got, exp);
        end
    endtask

    // Holds reset for five cycles with the given fuse levels.
    task automatic do_reset(input logic [2:0] f, input logic [2:0] m, input logic p);
        rst <= 1'b1;
        rfuse <= f;
        mfuse <= m;
        permit <= p;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask

    // One APB transfer: setup, access held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_w(rd, exp);
    endtask

    // Waits a bounded time for the current source to reach a code.
    task automatic wait_src(input logic [2:0] s, input int lim);
        for (int i = 0; i < lim && src !== s; i++)
            @(posedge clk);
        chk_w({29'h0, src}, {29'h0, s});
    endtask

    initial
    begin
        // Every fuse code sets request and current alike, bit 7 reads zero.
        for (int f = 0; f < 8; f++)
        begin
            do_reset(3'(f), 3'(f % 6), 1'b1);
            es = (f == 0 || f == 1 || f == 3) ? 3'h6 : 3'(f);
            ed = (f == 6) ? scss_pkg::DIV_4 : scss_pkg::DIV_1;
            rd_chk(scss_pkg::OFS_REQ, {25'h0, es, ed});
            rd_chk(scss_pkg::OFS_STAT, {25'h0, es, ed});
            chk_w({28'h0, freq}, (f == 0) ? 32'h8 : 32'h2);
            chk_w({29'h0, emode}, 32'(f % 6));
        end
        // Reserved source and divider codes are dropped and flagged.
        do_reset(3'h6, 3'h0, 1'b1);
        rd_chk(scss_pkg::OFS_IRQ_MSK, 32'h0);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h30);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h15);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h5A);
        rd_chk(scss_pkg::OFS_REQ, 32'h62);
        apb(1'b0, scss_pkg::OFS_IRQ_STS, 32'h0);
        chk_w(rd & 32'h4, 32'h4);
        // Status is read-only and an unmapped address errs.
        apb(1'b1, scss_pkg::OFS_STAT, 32'h11);
        rd_chk(scss_pkg::OFS_STAT, 32'h62);
        apb(1'b0, 12'h020, 32'h0);
        chk_w(rd, 32'h0);
        chk_b(err, 1'b1);
        // The old source runs on until the new one is ready.
        slow_rdy <= 1'b0;
        apb(1'b1, scss_pkg::OFS_IRQ_MSK, 32'h1);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h59);
        repeat (20) @(posedge clk);
        rd_chk(scss_pkg::OFS_STAT, 32'h62);
        chk_b(done, 1'b0);
        slow_rdy <= 1'b1;
        wait_src(3'h5, 50);
        chk_w({28'h0, div}, 32'h9);
        rd_chk(scss_pkg::OFS_STAT, 32'h59);
        chk_b(done, 1'b1);
        chk_b(irq, 1'b1);
        apb(1'b1, scss_pkg::OFS_IRQ_STS, 32'h1);
        // The clear lands at the access edge, so the level is looked at one edge later.
        @(posedge clk);
        chk_b(irq, 1'b0);
        // A crystal is used only after its startup count.
        do_reset(3'h6, scss_pkg::EXT_LP_XTAL, 1'b1);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h70);
        repeat (500) @(posedge clk);
        chk_w({29'h0, src}, 32'h6);
        wait_src(3'h7, 3000);
        pll_lock <= 1'b0;
        apb(1'b1, scss_pkg::OFS_REQ, 32'h20);
        repeat (20) @(posedge clk);
        chk_w({29'h0, src}, 32'h7);
        pll_lock <= 1'b1;
        wait_src(3'h2, 50);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h40);
        wait_src(3'h4, 50);
        // Without the permit fuse writes are ignored.
        do_reset(3'h6, 3'h0, 1'b0);
        apb(1'b1, scss_pkg::OFS_REQ, 32'h50);
        rd_chk(scss_pkg::OFS_REQ, 32'h62);
        // Loss of the external clock falls back to the fast oscillator.
        do_reset(3'h7, 3'h0, 1'b1);
        apb(1'b1, scss_pkg::OFS_IRQ_MSK, 32'h2);
        @(posedge clk);
        chk_b(irq, 1'b0);
        tick_on <= 1'b0;
        wait_src(3'h6, 300);
        rd_chk(scss_pkg::OFS_REQ, 32'h60);
        chk_b(irq, 1'b1);
        apb(1'b1, scss_pkg::OFS_IRQ_STS, 32'h2);
        @(posedge clk);
        chk_b(irq, 1'b0);
        tick_on <= 1'b1;
        stop_test();
    end
endmodule
